// >>> logic/autoneg_partner_page_regs.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module autoneg_partner_page_regs
  import autoneg_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic rx_word_valid,
  input wire logic [15:0] rx_word,
  input wire logic partner_word_ack,
  input wire logic an_restart,
  input wire logic parallel_fault,
  input wire logic partner_an_able,
  input wire logic np_word_sent,
  output logic [15:0] partner_ability,
  output logic [15:0] np_tx_word,
  output logic preamble_suppress,
  output logic [5:0] preamble_bits_needed
);

  logic [15:0] lp_q;
  logic [15:0] np_q;
  logic pd_fault_q;
  logic page_rx_q;
  logic lp_an_q;
  logic pre_supp_q;
  logic [5:0] pre_bits_q;
  logic [15:0] rdata_q;
  logic [15:0] exp_view;
  logic exp_read;

  assign exp_read = reg_rd && (reg_addr == ADDR_EXPANSION);

  always_comb begin
    exp_view = 16'h0000;
    exp_view[EXP_PD_FAULT_BIT] = pd_fault_q;
    exp_view[EXP_LP_NP_BIT] = lp_q[LP_MORE_PAGES_BIT];
    exp_view[EXP_NP_ABLE_BIT] = 1'b1;
    exp_view[EXP_PAGE_RX_BIT] = page_rx_q;
    exp_view[EXP_LP_AN_BIT] = lp_an_q;
  end

  // partner base page: stored with bits 12..11 cleared, 15 only feeds expansion bit 3, nothing acts on 13
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lp_q <= LP_RESET;
    end else if (rx_word_valid) begin
      // a word landing with a restart wins, so it is never lost
      lp_q <= rx_word & LP_STORE_MASK;
    end else if (an_restart) begin
      lp_q <= lp_q & LP_RESTART_CLR_MASK;
    end else if (partner_word_ack) begin
      lp_q[LP_ACK_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pd_fault_q <= 1'b0;
    end else if (parallel_fault) begin
      pd_fault_q <= 1'b1;
    end else if (exp_read) begin
      pd_fault_q <= 1'b0;
    end
  end

  // page received is set by any valid word, with no check or acknowledge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      page_rx_q <= 1'b0;
    end else if (rx_word_valid) begin
      page_rx_q <= 1'b1;
    end else if (exp_read) begin
      page_rx_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lp_an_q <= 1'b0;
    end else begin
      lp_an_q <= partner_an_able;
    end
  end

  // read-only bits keep their value whatever software writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      np_q <= NP_RESET;
    end else begin
      if (reg_wr && (reg_addr == ADDR_NP_TRANSMIT)) begin
        np_q <= (reg_wdata & NP_WRITE_MASK) | (np_q & ~NP_WRITE_MASK);
      end
      if (np_word_sent) begin
        np_q[NP_TOGGLE_BIT] <= ~np_q[NP_TOGGLE_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_supp_q <= MGMT_PRE_SUPP_RESET;
    end else if (reg_wr && (reg_addr == ADDR_MGMT_CTRL)) begin
      pre_supp_q <= reg_wdata[MGMT_PRE_SUPP_BIT];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_bits_q <= PREAMBLE_FULL_BITS;
    end else if (pre_supp_q) begin
      pre_bits_q <= PREAMBLE_SUPP_BITS;
    end else begin
      pre_bits_q <= PREAMBLE_FULL_BITS;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
    end else if (!reg_rd) begin
      rdata_q <= 16'h0000;
    end else if (reg_addr == ADDR_PARTNER_ABILITY) begin
      rdata_q <= lp_q;
    end else if (reg_addr == ADDR_EXPANSION) begin
      rdata_q <= exp_view;
    end else if (reg_addr == ADDR_NP_TRANSMIT) begin
      rdata_q <= np_q & ~16'h4000;
    end else if (reg_addr == ADDR_MGMT_CTRL) begin
      rdata_q <= {15'h0000, pre_supp_q};
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_q;
  assign partner_ability = lp_q;
  assign np_tx_word = np_q;
  assign preamble_suppress = pre_supp_q;
  assign preamble_bits_needed = pre_bits_q;

endmodule : autoneg_partner_page_regs

// >>> logic/autoneg_pkg.sv
// Summary of operation
// - bit 15 stores partner next-page request
// - bit 14 shows partner acknowledged our word
// - bit 13 stores partner fault, no action
// - bit 10 shows partner pause capability
// - bits 9..5 show partner technology abilities
// - restart or reset clears bits 9..5
// - selector bits 4..0 stored, cleared on restart
// - parallel fault latches high, clears on read
// - expansion bit 3 mirrors partner next-page
// - expansion bit 2 always reads one
// - page received latches high, clears on read
// - bit 0 shows partner negotiation ability
// - next-page bit 15 writable, resets zero
// - message page bit 13 writable, resets one
// - compliance bit 12 writable, resets zero
// - toggle bit 11 read-only, inverts per page
// - code field 10..0 writable, resets one
// - reserved bits read as zero
// - preamble suppression needs 2 bits, not 32
package autoneg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam logic [7:0] ADDR_PARTNER_ABILITY = 8'h0a;
  localparam logic [7:0] ADDR_EXPANSION = 8'h0c;
  localparam logic [7:0] ADDR_NP_TRANSMIT = 8'h0e;
  localparam logic [7:0] ADDR_MGMT_CTRL = 8'h10;
  // bit positions
  localparam int unsigned LP_MORE_PAGES_BIT = 15;
  localparam int unsigned LP_ACK_BIT = 14;
  localparam int unsigned LP_FAULT_BIT = 13;
  localparam int unsigned EXP_PD_FAULT_BIT = 4;
  localparam int unsigned EXP_LP_NP_BIT = 3;
  localparam int unsigned EXP_NP_ABLE_BIT = 2;
  localparam int unsigned EXP_PAGE_RX_BIT = 1;
  localparam int unsigned EXP_LP_AN_BIT = 0;
  localparam int unsigned NP_TOGGLE_BIT = 11;
  localparam int unsigned MGMT_PRE_SUPP_BIT = 0;
  // masks
  localparam logic [15:0] LP_STORE_MASK = 16'he7ff;
  localparam logic [15:0] LP_RESTART_CLR_MASK = 16'hfc00;
  localparam logic [15:0] NP_WRITE_MASK = 16'hb7ff;
  // reset values
  localparam logic [15:0] LP_RESET = 16'h0000;
  localparam logic [15:0] NP_RESET = 16'h2001;
  localparam logic MGMT_PRE_SUPP_RESET = 1'b0;
  // preamble lengths in management clock bits
  localparam logic [5:0] PREAMBLE_FULL_BITS = 6'h20;
  localparam logic [5:0] PREAMBLE_SUPP_BITS = 6'h02;
endpackage : autoneg_pkg

// >>> dv/autoneg_assertions.sv
`timescale 1ns/1ps
module autoneg_chk import autoneg_pkg::*; (
  input wire logic clk, sys_rst, reg_rd, rx_word_valid, partner_word_ack,
  input wire logic an_restart, np_word_sent, preamble_suppress,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_rdata, rx_word, partner_ability, np_tx_word,
  input wire logic [5:0] preamble_bits_needed
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  word_load_a: assert property (
    rx_word_valid |=> partner_ability == ($past(rx_word) & LP_STORE_MASK))
    else $error("ability word not loaded");
  restart_clr_a: assert property (
    an_restart && !rx_word_valid |=> partner_ability[9:0] == 10'h0)
    else $error("restart left ability bits");
  ack_set_a: assert property (
    partner_word_ack && !rx_word_valid |=> partner_ability[14])
    else $error("partner ack not shown");
  rsv_zero_a: assert property (
    partner_ability[12:11] == 2'h0 && np_tx_word[14] == 1'b0)
    else $error("reserved bit set");
  exp_view_a: assert property (
    reg_rd && reg_addr == ADDR_EXPANSION |=> reg_rdata[15:5] == 11'h0
    && reg_rdata[3:2] == {$past(partner_ability[15]), 1'b1})
    else $error("expansion view wrong");
  // the gap cycle without a read keeps a read-clear from masking the set
  page_seen_a: assert property (
    rx_word_valid ##1 !reg_rd ##1 reg_rd && reg_addr == ADDR_EXPANSION
    |=> reg_rdata[1]) else $error("page received not latched");
  toggle_flip_a: assert property (
    np_word_sent |=> np_tx_word[11] != $past(np_tx_word[11]))
    else $error("toggle did not flip");
  preamble_len_a: assert property (
    preamble_bits_needed == ($past(preamble_suppress) ?
    PREAMBLE_SUPP_BITS : PREAMBLE_FULL_BITS)) else $error("preamble count");
endmodule : autoneg_chk
bind autoneg_partner_page_regs autoneg_chk chk_u (.*);

// >>> dv/lp_model.sv
`timescale 1ns/1ps
module lp_model (
  input wire logic clk,
  output logic v = 1'b0,
  output logic [15:0] w = 16'h0,
  output logic ack = 1'b0,
  output logic able = 1'b0
);
  // idle word line shows the inverse so a stale copy cannot pass
  task automatic send(input logic [15:0] x, input logic a);
    @(posedge clk) begin
      v <= !a;
      ack <= a;
      w <= x;
      able <= 1'b1;
    end
    @(posedge clk) begin
      v <= 1'b0;
      ack <= 1'b0;
      w <= ~x;
    end
  endtask : send
endmodule : lp_model

// >>> dv/autoneg_partner_page_regs_test.sv
`timescale 1ns/1ps
module autoneg_partner_page_regs_test import autoneg_pkg::*; ;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [7:0] addr = 8'h0;
  logic [15:0] wd = 16'h0;
  logic [15:0] rdata, pa, np, w;
  logic v, ack, able, ps;
  logic [5:0] pb;
  int err_count = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  lp_model lp_u (.clk(clk), .v(v), .w(w), .ack(ack), .able(able));
  autoneg_partner_page_regs dut_u (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .rx_word_valid(v), .rx_word(w),
    .partner_word_ack(ack), .an_restart(ev[0]), .parallel_fault(ev[1]),
    .partner_an_able(able), .np_word_sent(ev[2]), .partner_ability(pa),
    .np_tx_word(np), .preamble_suppress(ps), .preamble_bits_needed(pb));
  task automatic chk(input string n, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] x);
    @(posedge clk) begin
      addr <= a;
      wd <= x;
      wr <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk) begin
      addr <= a;
      rd <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk("rdata", rdata, e);
  endtask : rd_chk
  task automatic pulse(input logic [2:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= 3'h0;
  endtask : pulse
  task automatic t_word;
    rd_chk(ADDR_PARTNER_ABILITY, 16'h0000);
    rd_chk(ADDR_EXPANSION, 16'h0004);
    rd_chk(ADDR_NP_TRANSMIT, 16'h2001);
    rd_chk(8'h02, 16'h0000);
    pulse(3'h2);
    lp_u.send(16'hffff, 1'b0);
    rd_chk(ADDR_EXPANSION, 16'h001f);
    rd_chk(ADDR_EXPANSION, 16'h000d);
    // ability is only trusted once the exchange has finished
    rd_chk(ADDR_PARTNER_ABILITY, 16'he7ff);
  endtask : t_word
  task automatic t_restart;
    pulse(3'h1);
    wr_reg(ADDR_PARTNER_ABILITY, 16'h0000);
    rd_chk(ADDR_PARTNER_ABILITY, 16'he400);
    lp_u.send(16'h0000, 1'b0);
    lp_u.send(16'h0000, 1'b1);
    rd_chk(ADDR_PARTNER_ABILITY, 16'h4000);
    chk("ability out", pa, 16'h4000);
    rd_chk(ADDR_EXPANSION, 16'h0007);
  endtask : t_restart
  task automatic t_np;
    wr_reg(ADDR_NP_TRANSMIT, 16'hffff);
    rd_chk(ADDR_NP_TRANSMIT, 16'hb7ff);
    pulse(3'h4);
    wr_reg(ADDR_NP_TRANSMIT, 16'h0000);
    rd_chk(ADDR_NP_TRANSMIT, 16'h0800);
    chk("np out", np, 16'h0800);
    wr_reg(ADDR_MGMT_CTRL, 16'h0001);
    rd_chk(ADDR_MGMT_CTRL, 16'h0001);
    chk("preamble", {10'h0, pb}, 16'h0002);
    chk("suppress", {15'h0, ps}, 16'h0001);
    wr_reg(ADDR_MGMT_CTRL, 16'h0000);
    rd_chk(ADDR_MGMT_CTRL, 16'h0000);
    chk("preamble full", {10'h0, pb}, 16'h0020);
    chk("suppress off", {15'h0, ps}, 16'h0000);
  endtask : t_np
  task automatic report_and_stop;
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_word;
    t_restart;
    t_np;
    report_and_stop;
  end
  initial begin
    #20000;
    err_count++;
    report_and_stop;
  end
endmodule : autoneg_partner_page_regs_test
